// >>> design/ecr_pkg.sv
// Constants shared by the clock, reset and board glue around the core.
// Assumes a 200 MHz system clock, a 100 MHz oscillator and an asynchronous active-high reset.
package ecr_pkg;
	localparam int unsigned OSC_HZ         = 100_000_000;
	localparam int unsigned CORE_HZ        = 32_500_000;
	localparam int unsigned RTC_HZ         = 32_000;
	// Fractional accumulator: add CORE_HZ*2 per oscillator edge, wrap at OSC_HZ
	localparam logic [31:0] CLK_ACC_STEP   = 32'(CORE_HZ * 2);
	localparam logic [31:0] CLK_ACC_WRAP   = 32'(OSC_HZ);
	// Oscillator edges per half period of the tick
	localparam int unsigned RTC_HALF_CYC   = OSC_HZ / (RTC_HZ * 2);
	localparam logic [11:0] RTC_HALF_LAST  = 12'(RTC_HALF_CYC - 1);
	localparam logic [31:0] VEC_FLASH      = 32'h4040_0000;
	localparam logic [31:0] VEC_DEBUG      = 32'h0000_0000;
	localparam int unsigned RST_STRETCH    = 16;
	localparam logic [4:0]  RST_CNT_LAST   = 5'(RST_STRETCH - 1);
	localparam int unsigned GPIO_W         = 16;
	localparam logic [15:0] GPIO_OUT_MASK  = 16'h0007;
	localparam logic [15:0] GPIO_IN_MASK   = 16'h00f8;
	localparam logic [15:0] GPIO_RESET     = 16'h0000;
endpackage

// >>> design/ecr_clk_if.sv
// Divided square-wave clock and tick shared between the top and the divider.
// Assumes both ends sit on the oscillator clock.
`timescale 1ns/10ps
interface ecr_clk_if;
	logic core_clk;
	logic rtc_tick;
	modport gen (output core_clk, output rtc_tick);
	modport use_side (input core_clk, input rtc_tick);
endinterface

// >>> design/ecr_clk_div.sv
// Derives the core clock and the real-time tick from the oscillator.
// Assumes i_osc is the free-running 100 MHz board oscillator.
`timescale 1ns/10ps
module ecr_clk_div
	import ecr_pkg::*;
(
	input  wire logic i_osc,
	input  wire logic i_sys_rst,
	ecr_clk_if.gen    clk_bus
);
	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic        clk_reg;
	logic [11:0] rtc_cnt_reg;
	logic        rtc_reg;
	logic [32:0] acc_sum;
	logic        acc_wrap;
	logic        rtc_last;

	// Phase accumulator: 65 half-periods per 100 oscillator edges, jitter of one edge
	assign acc_sum  = {1'b0, acc_reg} + {1'b0, CLK_ACC_STEP};
	assign acc_wrap = acc_sum >= {1'b0, CLK_ACC_WRAP};
	assign acc_next = acc_wrap ? 32'(acc_sum - {1'b0, CLK_ACC_WRAP}) : acc_sum[31:0];
	assign rtc_last = rtc_cnt_reg == RTC_HALF_LAST;

	always_ff @(posedge i_osc or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			acc_reg <= 32'h0;
			clk_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			clk_reg <= clk_reg ^ acc_wrap;
		end
	end

	always_ff @(posedge i_osc or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rtc_cnt_reg <= 12'h0;
			rtc_reg     <= 1'b0;
		end else begin
			rtc_cnt_reg <= rtc_last ? 12'h0 : rtc_cnt_reg + 12'h1;
			rtc_reg     <= rtc_reg ^ rtc_last;
		end
	end

	assign clk_bus.core_clk = clk_reg;
	assign clk_bus.rtc_tick = rtc_reg;
endmodule

// >>> design/ecr_glue.sv
// Board glue: clocks, reset merge, reset vector, interrupt and LED routing.
// Assumes i_mclk is a 200 MHz system clock and a separate 100 MHz oscillator drives
// input i_osc; board pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
module ecr_glue
	import ecr_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_osc,
	input  wire logic        i_reset_button,
	input  wire logic        i_debugger_system_reset_n,
	input  wire logic        i_core_ndreset,
	input  wire logic        i_core_dmactive,
	input  wire logic [3:0]  i_switch,
	input  wire logic [3:0]  i_button,
	input  wire logic [7:0]  i_header,
	input  wire logic [15:0] i_gpio_out,
	input  wire logic [15:0] i_gpio_oe,
	output logic             o_core_clock_out,
	output logic             o_periph_clock,
	output logic             o_rtc_tick,
	output logic             o_core_reset,
	output logic [31:0]      o_reset_vector,
	output logic [3:0]       o_global_irq,
	output logic [7:0]       o_local_irq,
	output logic [15:0]      o_gpio_in,
	output logic [2:0]       o_led0_rgb,
	output logic             o_led_sys_reset,
	output logic             o_led_dbg_reset,
	output logic             o_led_dmactive
);
	ecr_clk_if clk_bus ();

	ecr_clk_div u_div (
		.i_osc     (i_osc),
		.i_sys_rst (i_sys_rst),
		.clk_bus   (clk_bus)
	);

	// Two-flop synchronisers for every board pin
	localparam int unsigned SYNC_W = 1 + 1 + 1 + 1 + 4 + 4 + 8;
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;

	assign pin_raw = {i_reset_button, ~i_debugger_system_reset_n, i_core_ndreset,
		i_core_dmactive, i_switch, i_button, i_header};

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic       btn_rst_s;
	logic       dbg_rst_s;
	logic       ndreset_s;
	logic       dmactive_s;
	logic [3:0] switch_s;
	logic [3:0] button_s;
	logic [7:0] header_s;

	assign {btn_rst_s, dbg_rst_s, ndreset_s, dmactive_s, switch_s, button_s, header_s} = sync2_reg;

	// Either source alone forces the full system reset
	logic full_rst;
	logic core_rst_req;
	assign full_rst     = btn_rst_s | dbg_rst_s;
	assign core_rst_req = full_rst | ndreset_s;

	// Stretch the core reset so a glitchy button still gives a clean pulse
	logic [4:0] rst_cnt_reg;
	logic       core_rst_reg;
	logic       vec_sel_reg;
	logic       rst_done;
	assign rst_done = rst_cnt_reg == RST_CNT_LAST;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rst_cnt_reg  <= 5'h0;
			core_rst_reg <= 1'b1;
		end else if (core_rst_req) begin
			rst_cnt_reg  <= 5'h0;
			core_rst_reg <= 1'b1;
		end else if (!rst_done) begin
			rst_cnt_reg  <= rst_cnt_reg + 5'h1;
			core_rst_reg <= 1'b1;
		end else begin
			core_rst_reg <= 1'b0;
		end
	end

	// Vector switch sampled while the core is held, so it cannot move mid-run
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			vec_sel_reg <= 1'b0;
		end else if (core_rst_reg) begin
			vec_sel_reg <= switch_s[0];
		end
	end

	logic [31:0] vec_wire;
	assign vec_wire = vec_sel_reg ? VEC_DEBUG : VEC_FLASH;

	// GPIO inputs: bits 3..7 are board inputs only, 8..15 header pins
	logic [15:0] gpio_in_wire;
	assign gpio_in_wire = {header_s, button_s, switch_s[3], 3'b000} & ~GPIO_OUT_MASK;

	logic [2:0] led0_wire;
	assign led0_wire = i_gpio_out[2:0] & i_gpio_oe[2:0];

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reset_vector  <= VEC_FLASH;
			o_global_irq    <= 4'h0;
			o_local_irq     <= 8'h00;
			o_gpio_in       <= GPIO_RESET;
			o_led0_rgb      <= 3'b000;
			o_led_sys_reset <= 1'b1;
			o_led_dbg_reset <= 1'b0;
			o_led_dmactive  <= 1'b0;
		end else begin
			o_reset_vector  <= vec_wire;
			o_global_irq    <= switch_s;
			o_local_irq     <= {button_s, switch_s};
			o_gpio_in       <= gpio_in_wire;
			o_led0_rgb      <= led0_wire;
			o_led_sys_reset <= full_rst;
			o_led_dbg_reset <= dbg_rst_s;
			o_led_dmactive  <= dmactive_s;
		end
	end

	assign o_core_reset     = core_rst_reg;
	assign o_core_clock_out = clk_bus.core_clk;
	assign o_periph_clock   = clk_bus.core_clk;
	assign o_rtc_tick       = clk_bus.rtc_tick;
endmodule

// >>> sim/ecr_core_model.sv
// Core and debugger stand-in: ndreset on request, dmactive while the core runs.
// Assumes the bench clock; changes just after the rising edge, like the core.
`timescale 1ns/10ps
module ecr_core_model (
	input  wire logic i_mclk,
	input  wire logic i_core_reset,
	input  wire logic i_req,
	output logic      o_ndreset = 1'b0,
	output logic      o_dmactive = 1'b0
);
	always @(posedge i_mclk) begin
		o_ndreset <= i_req;
		o_dmactive <= !i_core_reset;
	end
endmodule

// >>> sim/ecr_glue_assertions.sv
// Port checks of the board glue: pin routing, reset merge and reset vector.
// Assumes board pins stay still while i_sys_rst is high; bound at the foot.
`timescale 1ns/10ps
module ecr_glue_assertions
	import ecr_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_reset_button,
	input wire logic        i_debugger_system_reset_n,
	input wire logic        i_core_ndreset,
	input wire logic [3:0]  i_switch,
	input wire logic [3:0]  i_button,
	input wire logic [15:0] i_gpio_out,
	input wire logic [15:0] i_gpio_oe,
	input wire logic        o_core_reset,
	input wire logic [31:0] o_reset_vector,
	input wire logic [3:0]  o_global_irq,
	input wire logic [7:0]  o_local_irq,
	input wire logic [2:0]  o_led0_rgb
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// Four calm samples cover the two sync flops and the output register
	sequence s_calm; $stable({i_switch, i_button, i_gpio_out, i_gpio_oe})[*4]; endsequence
	property p_gi; s_calm |-> o_global_irq == i_switch; endproperty
	a_gi: assert property (p_gi) else $error("global irq");
	property p_li; s_calm |-> o_local_irq == {i_button, i_switch}; endproperty
	a_li: assert property (p_li) else $error("local irq");
	property p_led; s_calm |-> o_led0_rgb == (i_gpio_out[2:0] & i_gpio_oe[2:0]); endproperty
	a_led: assert property (p_led) else $error("led0");
	property p_btn; i_reset_button |-> ##[1:3] o_core_reset; endproperty
	a_btn: assert property (p_btn) else $error("button reset");
	property p_dbg; !i_debugger_system_reset_n |-> ##[1:3] o_core_reset; endproperty
	a_dbg: assert property (p_dbg) else $error("debugger reset");
	property p_ndr; i_core_ndreset |-> ##[1:3] o_core_reset; endproperty
	a_ndr: assert property (p_ndr) else $error("ndreset");
	property p_vec; $fell(o_core_reset) |-> o_reset_vector == ($past(i_switch[0], 4) ? VEC_DEBUG : VEC_FLASH); endproperty
	a_vec: assert property (p_vec) else $error("vector");
	// Vector must not move under a running core
	property p_frz; !o_core_reset [*3] |-> $stable(o_reset_vector); endproperty
	a_frz: assert property (p_frz) else $error("vector moved");
endmodule
bind ecr_glue ecr_glue_assertions u_chk (.*);

// >>> sim/ecr_glue_bench.sv
// Self-checking bench: routing, reset merge, vector, clocks and tick.
// Assumes the core model stands in for the core and the debugger.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module ecr_glue_bench
	import ecr_pkg::*;
;
	logic i_mclk = 0, i_osc = 0, i_sys_rst = 1, i_reset_button = 0, i_debugger_system_reset_n = 1, ndr_req = 0;
	logic i_core_ndreset, i_core_dmactive, o_core_clock_out, o_periph_clock, o_rtc_tick, o_core_reset;
	logic o_led_sys_reset, o_led_dbg_reset, o_led_dmactive;
	logic [3:0] i_switch = '0, i_button = '0, o_global_irq;
	logic [7:0] i_header = '0, o_local_irq;
	logic [15:0] i_gpio_out = '0, i_gpio_oe = '0, o_gpio_in;
	logic [31:0] o_reset_vector;
	logic [2:0] o_led0_rgb;
	logic [30:0] q[$], seen, exp_v;
	int n_errors = 0, n_compared = 0, k, n0, n_cc = 0, n_pc = 0, n_osc = 0;
	wire [30:0] obs = {o_global_irq, o_local_irq, o_gpio_in, o_led0_rgb};
	always #2.5 i_mclk = ~i_mclk;
	always #5 i_osc = ~i_osc;
	always @(posedge o_core_clock_out) n_cc++;
	always @(posedge o_periph_clock) n_pc++;
	always @(posedge i_osc) n_osc++;
	ecr_glue u_dut (.*);
	ecr_core_model u_core (.i_mclk(i_mclk), .i_core_reset(o_core_reset), .i_req(ndr_req), .o_ndreset(i_core_ndreset),
		.o_dmactive(i_core_dmactive));
	// Pins cross two sync flops while GPIO does not, so poke skews GPIO to land on the same edge
	always @(negedge i_mclk) begin
		if (q.size() > 0 && obs !== seen) begin
			exp_v = q.pop_front();
			`CHK("routing", exp_v, obs)
		end
		seen = obs;
	end
	task automatic poke(input logic sw0);
		logic [46:0] r;
		@(negedge i_mclk);
		r = 47'({$urandom, $urandom});
		{i_switch, i_button, i_header[7:1]} = {r[46:44], sw0, r[42:32]};
		// Header bit 0 toggles so every poke shows at the outputs
		i_header[0] = ~i_header[0];
		// GPIO is same-clock and skips the sync flops: drive it two cycles later
		repeat (2) @(negedge i_mclk);
		{i_gpio_out, i_gpio_oe} = r[31:0];
		q.push_back({i_switch, i_button, i_switch, i_header, i_button, i_switch[3], 3'h0, i_gpio_out[2:0] & i_gpio_oe[2:0]});
		repeat (3) @(negedge i_mclk);
	endtask
	task automatic rst_src(input int s, input logic sw0);
		poke(sw0);
		{i_reset_button, i_debugger_system_reset_n, ndr_req} = {s == 0, s != 1, s == 2};
		repeat (5) @(negedge i_mclk);
		`CHK("core_reset", 1'b1, o_core_reset)
		`CHK("led_sys", 1'(s < 2), o_led_sys_reset)
		`CHK("led_dbg", 1'(s == 1), o_led_dbg_reset)
		{i_reset_button, i_debugger_system_reset_n, ndr_req} = 3'b010;
		repeat (12) @(negedge i_mclk);
		`CHK("stretch", 1'b1, o_core_reset)
		repeat (14) @(negedge i_mclk);
		`CHK("release", 1'b0, o_core_reset)
		`CHK("vector", sw0 ? VEC_DEBUG : VEC_FLASH, o_reset_vector)
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		k = $urandom(27441);
		repeat (16) @(negedge i_mclk);
		i_sys_rst = 0;
		repeat (30) @(negedge i_mclk);
		`CHK("boot_vector", VEC_FLASH, o_reset_vector)
		for (k = 0; k < 6; k++)
			rst_src(k % 3, 1'(k));
		$display("reset tests done");
		repeat (16)
			poke(1'($urandom));
		$display("routing tests done");
		n0 = n_cc;
		repeat (2000) @(negedge i_mclk);
		`CHK("core_clock", 1'b1, 1'((n_cc - n0) inside {[324:326]}))
		`CHK("periph_clock", n_cc, n_pc)
		@(posedge o_rtc_tick);
		n0 = n_osc;
		@(negedge o_rtc_tick);
		`CHK("rtc_half", RTC_HALF_CYC, n_osc - n0)
		`CHK("dmactive", 1'b1, o_led_dmactive)
		$display("clock tests done");
		results();
	end
	// Whole run is near 31 us; this leaves ample margin
	initial begin
		#150000;
		n_errors++;
		results();
	end
endmodule
